// >>> wwd_map.vh
// Register map, field positions, reset values and timing counts for
// the windowed watchdog core.
// Assumes an 8-bit register port addressed by the printed byte offsets.
// Functional notes
// - Config-b bit 7: write-once early-refresh window mode enable.
// - Config-b bit 6: interrupt flag, set on delayed-reset event, write 1 clears.
// - Config-b bits 5 and 3..2 read zero, writes ignored.
// - Config-b bit 4: write-once divide-by-256 of counter reference clock.
// - Config-b bits 1..0: write-once clock select bus, 1k, 32k, external.
// - Counter bytes read the live counter at any time.
// - Valid refresh sequence clears the counter to zero.
// - Unlock sequence opens reconfiguration only if allow-updates was set.
// - Any other counter write forces a reset.
// - Counter reaching 16-bit timeout value forces a reset.
// - In window mode the window value is the earliest valid refresh count.
// - Counter runs continuously from selected source; no refresh means reset.
// - Refresh is 0xA602 then 0xB480 within 16 bus clocks, else reset.
// - Unlock is 0xC520 then 0xD928; reconfigure within 128 clocks, else reset.
// - With interrupts enabled, request interrupt and delay reset 128 clocks.
// - In window mode a refresh before the window value forces a reset.
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WWD_CFGA_ADDR   16'h3030
`define WWD_CFGB_ADDR   16'h3031
`define WWD_CNTH_ADDR   16'h3032
`define WWD_CNTL_ADDR   16'h3033
`define WWD_TOH_ADDR    16'h3034
`define WWD_TOL_ADDR    16'h3035
`define WWD_WINH_ADDR   16'h3036
`define WWD_WINL_ADDR   16'h3037

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WWD_A_EN        7
`define WWD_A_INT       6
`define WWD_A_UPDATE    5
`define WWD_B_WIN       7
`define WWD_B_FLG       6
`define WWD_B_DIV256_ENABLE      4
`define WWD_B_CLK_HI    1
`define WWD_B_CLK_LO    0
`define WWD_B_RW_MASK   8'h93

// ----------------------------------------------------------------------
// Reset values and sequence words
// ----------------------------------------------------------------------
`define WWD_CFGA_RST    8'h80
`define WWD_CFGB_RST    8'h01
`define WWD_TO_RST      16'h0004
`define WWD_WIN_RST     16'h0000
`define WWD_REF1        16'hA602
`define WWD_REF2        16'hB480
`define WWD_UNL1        16'hC520
`define WWD_UNL2        16'hD928

// ----------------------------------------------------------------------
// Timing counts in bus clocks
// ----------------------------------------------------------------------
`define WWD_SEQ_GAP     8'h10
`define WWD_CFG_TIME    8'h80
`define WWD_RST_DELAY   8'h80
`define WWD_DIV256_ENABLE_DIV    256

`endif

// >>> wwd_tick_gen.v
// Counter tick generator for the windowed watchdog core.
// Assumes slow source clocks arrive as raw pins on no known phase.
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_tick_gen (
   input  wire       ref_clk,    // Bus clock
   input  wire       rst_b,      // Async reset, active low
   input  wire [1:0] clk_sel,    // Source select
   input  wire       div256,     // Divide-by-256 enable
   input  wire       lpo_1k,     // 1 kHz source pin
   input  wire       irc_32k,    // 32 kHz source pin
   input  wire       ext_clk,    // External source pin
   output reg        tick        // One-cycle count enable
);

   reg  [2:0] sync_lpo;
   reg  [2:0] sync_irc;
   reg  [2:0] sync_ext;
   reg        prev_lvl;
   reg  [7:0] div256_enable_cnt;
   reg        src_lvl;
   wire       src_edge;

   // ----------------------------------------------------------------------
   // Three-stage synchronisers; levels taken when stages 2 and 3 agree
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_lpo <= 3'h0;
         sync_irc <= 3'h0;
         sync_ext <= 3'h0;
      end else begin
         sync_lpo <= {sync_lpo[1:0], lpo_1k};
         sync_irc <= {sync_irc[1:0], irc_32k};
         sync_ext <= {sync_ext[1:0], ext_clk};
      end
   end

   // Source mux; bus clock means every cycle counts
   always @* begin
      case (clk_sel)
         2'h1:    src_lvl = (sync_lpo[2] == sync_lpo[1]) ? sync_lpo[2] : prev_lvl;
         2'h2:    src_lvl = (sync_irc[2] == sync_irc[1]) ? sync_irc[2] : prev_lvl;
         2'h3:    src_lvl = (sync_ext[2] == sync_ext[1]) ? sync_ext[2] : prev_lvl;
         default: src_lvl = 1'b0;
      endcase
   end

   assign src_edge = (clk_sel == 2'h0) ? 1'b1 : (src_lvl & ~prev_lvl);

   // Rising-edge detect and fixed prescaler
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_lvl <= 1'b0;
         div256_enable_cnt <= 8'h00;
         tick     <= 1'b0;
      end else begin
         prev_lvl <= src_lvl;
         tick     <= 1'b0;
         if (src_edge) begin
            if (!div256) begin
               tick <= 1'b1;
            end else begin
               div256_enable_cnt <= div256_enable_cnt + 8'h01;
               tick     <= (div256_enable_cnt == 8'hFF);
            end
         end
      end
   end

endmodule

// >>> wwd_core.v
// Windowed watchdog core: registers, counter, sequences and reset.
// Assumes an 8-bit register port with one-cycle strobes on ref_clk.
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_core (
   input  wire        ref_clk,   // Bus clock, 200 MHz
   input  wire        rst_b,     // Async reset, active low
   input  wire [15:0] addr,      // Register byte address
   input  wire [7:0]  wdata,     // Write data
   input  wire        wr_en,     // Write strobe
   input  wire        rd_en,     // Read strobe
   output reg  [7:0]  rdata,     // Read data, cycle after rd_en
   input  wire        lpo_1k,    // 1 kHz oscillator pin
   input  wire        irc_32k,   // 32 kHz oscillator pin
   input  wire        ext_clk,   // External clock pin
   output reg         wdog_irq,  // Interrupt request level
   output reg         wdog_rst   // Forced reset request level
);

   // Windows and delays in bus clocks
   localparam [7:0] SEQ_GAP  = `WWD_SEQ_GAP;
   localparam [7:0] CFG_TIME = `WWD_CFG_TIME;
   localparam [7:0] RST_DLY  = `WWD_RST_DELAY;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg  [7:0]  cfg_a;
   reg         win_en;
   reg         irq_flag;
   reg         div256_enable;
   reg  [1:0]  clk_sel;
   reg  [15:0] timeout;
   reg  [15:0] early_limit;
   reg  [15:0] count;
   reg  [7:0]  cnt_hi_hold;       // Upper byte of a pending counter write
   reg         hi_held;
   reg         first_word;        // First sequence word seen
   reg         first_is_ref;      // First word was refresh, else unlock
   reg  [7:0]  gap_cnt;
   reg         locked;            // Write-once fields closed
   reg         unlock_open;       // Reconfiguration interval running
   reg  [7:0]  unl_cnt;
   reg  [7:0]  cfg_cnt;           // Initial configuration window
   reg         cfg_done;
   reg         pend;              // Delayed reset pending
   reg  [7:0]  dly_cnt;
   wire        tick;
   wire        can_cfg;
   wire        wr_cnt;
   wire [15:0] word;
   wire        word_done;
   reg         fault;
   reg         refresh_ok;

   assign can_cfg   = ~locked | unlock_open;
   assign wr_cnt    = wr_en & ((addr == `WWD_CNTH_ADDR) |
                               (addr == `WWD_CNTL_ADDR));
   assign word      = {cnt_hi_hold, wdata};
   assign word_done = wr_en & (addr == `WWD_CNTL_ADDR) & hi_held;

   // ----------------------------------------------------------------------
   // Tick source
   // ----------------------------------------------------------------------
   wwd_tick_gen u_tick (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clk_sel (clk_sel),
      .div256  (div256_enable),
      .lpo_1k  (lpo_1k),
      .irc_32k (irc_32k),
      .ext_clk (ext_clk),
      .tick    (tick)
   );

   // ----------------------------------------------------------------------
   // Fault detection: any event that triggers a reset
   // ----------------------------------------------------------------------
   always @* begin
      fault      = 1'b0;
      refresh_ok = 1'b0;
      // Timeout compare; a zero timeout fires at once
      if (cfg_a[`WWD_A_EN] && count >= timeout)
         fault = 1'b1;
      // Second word late
      if (first_word && gap_cnt >= SEQ_GAP)
         fault = 1'b1;
      // Unlock interval expired without reconfiguration finishing
      if (unlock_open && unl_cnt >= CFG_TIME)
         fault = 1'b1;
      // Lone low-byte write or stray word is illegal
      if (wr_en && addr == `WWD_CNTL_ADDR && !hi_held)
         fault = 1'b1;
      if (word_done) begin
         if (!first_word) begin
            if (word != `WWD_REF1 && word != `WWD_UNL1)
               fault = 1'b1;
            else if (word == `WWD_UNL1 && !cfg_a[`WWD_A_UPDATE])
               fault = 1'b1;
            else if (word == `WWD_REF1 && win_en && count < early_limit)
               fault = 1'b1;
         end else if (first_is_ref) begin
            if (word == `WWD_REF2)
               refresh_ok = 1'b1;
            else
               fault = 1'b1;
         end else if (word != `WWD_UNL2) begin
            fault = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Counter and sequence tracking
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count        <= 16'h0000;
         cnt_hi_hold  <= 8'h00;
         hi_held      <= 1'b0;
         first_word   <= 1'b0;
         first_is_ref <= 1'b0;
         gap_cnt      <= 8'h00;
         unlock_open  <= 1'b0;
         unl_cnt      <= 8'h00;
      end else begin
         // Free-running count from the chosen source
         if (refresh_ok)
            count <= 16'h0000;
         else if (cfg_a[`WWD_A_EN] && tick && count != 16'hFFFF)
            count <= count + 16'h0001;
         if (wr_en && addr == `WWD_CNTH_ADDR) begin
            cnt_hi_hold <= wdata;
            hi_held     <= 1'b1;
         end else if (wr_cnt) begin
            hi_held <= 1'b0;
         end
         // Gap timer runs between the two words
         if (first_word)
            gap_cnt <= gap_cnt + 8'h01;
         if (word_done && !first_word) begin
            first_word   <= 1'b1;
            first_is_ref <= (word == `WWD_REF1);
            gap_cnt      <= 8'h00;
         end else if (word_done) begin
            first_word <= 1'b0;
         end
         // Unlock opens the reconfiguration interval
         if (word_done && first_word && !first_is_ref &&
             word == `WWD_UNL2) begin
            unlock_open <= 1'b1;
            unl_cnt     <= 8'h00;
         end else if (unlock_open) begin
            unl_cnt <= unl_cnt + 8'h01;
            if (wr_en && addr == `WWD_CFGA_ADDR)
               unlock_open <= 1'b0;    // Config-a write closes the interval
         end
      end
   end

   // ----------------------------------------------------------------------
   // Write-once configuration registers
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_a         <= `WWD_CFGA_RST;
         win_en        <= 1'b0;
         div256_enable <= 1'b0;
         clk_sel       <= 2'h1;
         timeout       <= `WWD_TO_RST;
         early_limit   <= `WWD_WIN_RST;
         locked        <= 1'b0;
         cfg_cnt       <= 8'h00;
         cfg_done      <= 1'b0;
      end else begin
         // Initial window closes after 128 bus clocks
         if (!cfg_done) begin
            cfg_cnt <= cfg_cnt + 8'h01;
            if (cfg_cnt == CFG_TIME - 8'h01) begin
               cfg_done <= 1'b1;
               locked   <= 1'b1;
            end
         end
         if (wr_en && can_cfg) begin
            case (addr)
               `WWD_CFGA_ADDR: begin
                  cfg_a  <= wdata;
                  locked <= 1'b1;
               end
               `WWD_CFGB_ADDR: begin
                  win_en        <= wdata[`WWD_B_WIN];
                  div256_enable <= wdata[`WWD_B_DIV256_ENABLE];
                  clk_sel       <= wdata[`WWD_B_CLK_HI:`WWD_B_CLK_LO];
               end
               `WWD_TOH_ADDR:  timeout[15:8]     <= wdata;
               `WWD_TOL_ADDR:  timeout[7:0]      <= wdata;
               `WWD_WINH_ADDR: early_limit[15:8] <= wdata;
               `WWD_WINL_ADDR: early_limit[7:0]  <= wdata;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt flag and delayed reset
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_flag <= 1'b0;
         pend     <= 1'b0;
         dly_cnt  <= 8'h00;
         wdog_irq <= 1'b0;
         wdog_rst <= 1'b0;
      end else begin
         // Set wins over a same-cycle write-1 clear
         if (fault && cfg_a[`WWD_A_INT] && !pend)
            irq_flag <= 1'b1;
         else if (wr_en && addr == `WWD_CFGB_ADDR && wdata[`WWD_B_FLG])
            irq_flag <= 1'b0;
         if (fault && !cfg_a[`WWD_A_INT]) begin
            wdog_rst <= 1'b1;
         end else if (fault && !pend) begin
            pend     <= 1'b1;
            dly_cnt  <= 8'h00;
            wdog_irq <= 1'b1;
         end else if (pend) begin
            dly_cnt <= dly_cnt + 8'h01;
            if (dly_cnt == RST_DLY - 8'h01)
               wdog_rst <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read port; counter bytes are live reserved bits zero
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `WWD_CFGA_ADDR: rdata <= cfg_a;
            `WWD_CFGB_ADDR: rdata <= {win_en, irq_flag, 1'b0, div256_enable,
                                      2'h0, clk_sel};
            `WWD_CNTH_ADDR: rdata <= count[15:8];
            `WWD_CNTL_ADDR: rdata <= count[7:0];
            `WWD_TOH_ADDR:  rdata <= timeout[15:8];
            `WWD_TOL_ADDR:  rdata <= timeout[7:0];
            `WWD_WINH_ADDR: rdata <= early_limit[15:8];
            `WWD_WINL_ADDR: rdata <= early_limit[7:0];
            default:        rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule

// >>> wwd_props.sv
// Port-level assertions for the windowed watchdog core.
// Assumes binding to wwd_core; sees its ports and nothing inside.
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_props (
   input wire        ref_clk,   // Bus clock
   input wire        rst_b,     // Async reset, active low
   input wire [15:0] addr,      // Byte address
   input wire [7:0]  wdata,     // Write data
   input wire        wr_en,     // Write strobe
   input wire        rd_en,     // Read strobe
   input wire [7:0]  rdata,     // Read data
   input wire        wdog_irq,  // Interrupt level
   input wire        wdog_rst   // Reset request
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // High byte that no legal sequence word starts with
   wire bad_hi = wdata != 8'hA6 && wdata != 8'hB4 &&
                 wdata != 8'hC5 && wdata != 8'hD9;
   wire mapped = addr >= `WWD_CFGA_ADDR && addr <= `WWD_WINL_ADDR;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // One counter word: high byte then low byte
   sequence s_cw(hi, lo);
      wr_en && addr == `WWD_CNTH_ADDR && wdata == hi
      ##1 wr_en && addr == `WWD_CNTL_ADDR && wdata == lo;
   endsequence
   sequence s_refresh;
      s_cw(8'hA6, 8'h02) ##1 s_cw(8'hB4, 8'h80);
   endsequence

   property p_rdata_idle;
      !rd_en |=> rdata == 8'h00;
   endproperty
   property p_rsvd;
      rd_en && addr == `WWD_CFGB_ADDR |=> rdata[5] == 1'b0 &&
                                          rdata[3:2] == 2'b00;
   endproperty
   property p_unmapped;
      rd_en && !mapped |=> rdata == 8'h00;
   endproperty
   property p_rst_sticky;
      wdog_rst |=> wdog_rst;
   endproperty
   property p_irq_sticky;
      wdog_irq |=> wdog_irq;
   endproperty
   // Reset is held off after the interrupt, then comes exactly
   property p_irq_hold;
      $rose(wdog_irq) |-> !wdog_rst [*8];
   endproperty
   property p_irq_delay;
      $rose(wdog_irq) |-> ##128 $rose(wdog_rst);
   endproperty
   property p_bad_word;
      (wr_en && addr == `WWD_CNTH_ADDR && bad_hi)
      ##1 (wr_en && addr == `WWD_CNTL_ADDR)
      |-> ##[1:3] (wdog_rst || wdog_irq);
   endproperty
   property p_refresh_clear;
      s_refresh ##1 (rd_en && addr == `WWD_CNTH_ADDR && !wdog_rst &&
                     !wdog_irq) |=> rdata == 8'h00;
   endproperty

   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");
   a_rsvd: assert property (p_rsvd)
      else $error("reserved config bits read nonzero");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_rst_sticky: assert property (p_rst_sticky)
      else $error("reset request dropped");
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("interrupt request dropped");
   a_irq_hold: assert property (p_irq_hold)
      else $error("reset not held off after interrupt");
   a_irq_delay: assert property (p_irq_delay)
      else $error("delayed reset not at 128 clocks");
   a_bad_word: assert property (p_bad_word)
      else $error("illegal counter write gave no reset");
   a_refresh_clear: assert property (p_refresh_clear)
      else $error("counter not cleared by refresh");
endmodule

// >>> testbench.sv
// Self-checking bench for the windowed watchdog core.
// Assumes wwd_core and its map header; slow pins mostly held quiet.
`timescale 1ns/1ps
`include "wwd_map.vh"

module testbench;
   reg         ref_clk = 1'b0;
   reg         rst_b   = 1'b0;
   reg  [15:0] addr    = 16'h0000;
   reg  [7:0]  wdata   = 8'h00;
   reg         wr_en   = 1'b0;
   reg         rd_en   = 1'b0;
   reg         lpo_1k  = 1'b0;
   reg         irc_32k = 1'b0;
   reg         ext_clk = 1'b0;
   wire [7:0]  rdata;
   wire        wdog_irq;
   wire        wdog_rst;
   integer     mismatches = 0;
   integer     num_checks = 0;
   integer     seed       = 32;
   integer     cycles     = 0;
   integer     k, n, g;
   reg  [7:0]  rv, v1;

   wwd_core wwd_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .lpo_1k(lpo_1k), .irc_32k(irc_32k), .ext_clk(ext_clk),
      .wdog_irq(wdog_irq), .wdog_rst(wdog_rst));

   // -------------------------------------------------------------
   // Clock, hang guard, bus tasks
   // -------------------------------------------------------------
   always #2.5 ref_clk = ~ref_clk;

   // Whole run is well under this; a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         final_report;
      end
   end

   function [7:0] exp_cfgb(input [7:0] w);
      exp_cfgb = w & `WWD_B_RW_MASK;
   endfunction

   task final_report;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Each strobe set exactly once per step, so no back-to-back race
   task idle;
      begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         addr  <= a;
         wdata <= d;
         wr_en <= 1'b1;
         rd_en <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task rd(input [15:0] a);
      begin
         addr  <= a;
         rd_en <= 1'b1;
         wr_en <= 1'b0;
         @(posedge ref_clk);
         #1 rv = rdata;
      end
   endtask
   task word(input [15:0] w);
      begin
         wr(`WWD_CNTH_ADDR, w[15:8]);
         wr(`WWD_CNTL_ADDR, w[7:0]);
      end
   endtask
   task cfg(input [15:0] to, input [15:0] early_refresh_guard, input [7:0] b,
            input [7:0] a);
      begin
         wr(`WWD_TOH_ADDR, to[15:8]);
         wr(`WWD_TOL_ADDR, to[7:0]);
         wr(`WWD_WINH_ADDR, early_refresh_guard[15:8]);
         wr(`WWD_WINL_ADDR, early_refresh_guard[7:0]);
         wr(`WWD_CFGB_ADDR, b);
         wr(`WWD_CFGA_ADDR, a);
         idle;
      end
   endtask
   task do_reset;
      begin
         rst_b <= 1'b0;
         idle;
         repeat (8) @(posedge ref_clk);
         rst_b <= 1'b1;
         @(posedge ref_clk);
      end
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      do_reset;
      rd(`WWD_CFGB_ADDR);
      chk(rv, `WWD_CFGB_RST);
      cfg(16'h0100, 16'h0040, 8'hEC, 8'hA0);
      rd(`WWD_CFGB_ADDR);
      chk(rv, exp_cfgb(8'hEC));
      wr(`WWD_CFGB_ADDR, 8'h13);
      rd(`WWD_CFGB_ADDR);
      chk(rv, exp_cfgb(8'hEC));
      v1 = rv;
      rd(`WWD_CNTL_ADDR);
      v1 = rv;
      repeat (8) idle;
      rd(`WWD_CNTL_ADDR);
      chk(rv > v1, 1);
      repeat (80) idle;
      word(`WWD_REF1);
      word(`WWD_REF2);
      rd(`WWD_CNTH_ADDR);
      chk(rv, 8'h00);
      // Refreshes past the window, random spacing and word gap
      for (k = 0; k < 6; k = k + 1) begin
         n = 72 + ({$random(seed)} % 72);
         g = {$random(seed)} % 12;
         repeat (n) idle;
         word(`WWD_REF1);
         repeat (g) idle;
         word(`WWD_REF2);
         rd(`WWD_CNTH_ADDR);
         chk({rv, 7'h00, wdog_rst}, 16'h0000);
      end
      rd(16'h3038);
      chk(rv, 8'h00);
      word(`WWD_UNL1);
      word(`WWD_UNL2);
      cfg(16'h0100, 16'h0000, 8'h00, 8'hA0);
      word(`WWD_REF1);
      word(`WWD_REF2);
      rd(`WWD_CFGB_ADDR);
      chk(rv, exp_cfgb(8'h00));
      repeat (150) idle;
      chk(wdog_rst, 1'b0);
      // Each pass provokes one kind of forced reset
      for (k = 0; k < 10; k = k + 1) begin
         do_reset;
         case (k)
            0: repeat (12) begin
               lpo_1k <= ~lpo_1k;
               repeat (8) idle;
            end
            1: begin
               cfg(16'h1000, 16'h0000, 8'h00, 8'h80);
               word(16'h1234);
            end
            2: begin
               cfg(16'h1000, 16'h0000, 8'h00, 8'h80);
               word(`WWD_REF1);
               repeat (20) idle;
               word(`WWD_REF2);
            end
            3: begin
               cfg(16'h1000, 16'h0800, 8'h80, 8'h80);
               word(`WWD_REF1);
               word(`WWD_REF2);
            end
            4: begin
               cfg(16'h1000, 16'h0000, 8'h00, 8'h80);
               word(`WWD_UNL1);
            end
            5: begin
               cfg(16'h1000, 16'h0000, 8'h00, 8'hA0);
               word(`WWD_UNL1);
               word(`WWD_UNL2);
            end
            7, 8: begin
               cfg(16'h0004, 16'h0000, k[7:0] - 8'h05, 8'h80);
               repeat (8) idle;
               chk(wdog_rst, 1'b0);
               repeat (12) begin
                  if (k == 7) irc_32k <= ~irc_32k;
                  else ext_clk <= ~ext_clk;
                  repeat (8) idle;
               end
            end
            9: begin
               cfg(16'h0004, 16'h0000, 8'h10, 8'h80);
               repeat (1000) idle;
               chk(wdog_rst, 1'b0);
            end
            default: begin
               cfg(16'h0040, 16'h0000, 8'h00, 8'hC0);
               n = 0;
               while (wdog_irq !== 1'b1 && n < 300) begin
                  idle;
                  n = n + 1;
               end
               rd(`WWD_CFGB_ADDR);
               chk(rv, exp_cfgb(8'h00) | 8'h40);
               wr(`WWD_CFGB_ADDR, 8'h40);
               rd(`WWD_CFGB_ADDR);
               chk(rv, exp_cfgb(8'h00));
            end
         endcase
         idle;
         n = 0;
         while (wdog_rst !== 1'b1 && n < 400) begin
            idle;
            n = n + 1;
         end
         chk(wdog_rst, 1'b1);
         chk(wdog_irq, k == 6);
      end
      final_report;
   end
endmodule

bind wwd_core wwd_props wwd_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .wdog_irq(wdog_irq), .wdog_rst(wdog_rst));
